// file: rtl/sadc_defs.svh
// Constants for the converter readout link: widths, timing figures and cycle counts
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define SADC_RES_W 16
`define SADC_FRAME_W 17
`define SADC_CNT_W 5
`define SADC_TMR_W 6
`define SADC_LEN_PLAIN 5'h10
`define SADC_LEN_BUSY 5'h11
`define SADC_MSB_IDX 5'h10

// ----------------------------------------
// Timing figures in ns
// ----------------------------------------
`define SADC_MCLK_NS 40
`define SADC_CONV_MIN_NS 500
`define SADC_CONV_MAX_NS 710
`define SADC_CYCLE_MIN_NS 1000
`define SADC_ACQ_MIN_NS 290

// ----------------------------------------
// Cycle counts at the mclk rate
// ----------------------------------------
// Least times and longest times both round up
`define SADC_CONV_CYC (6'((`SADC_CONV_MIN_NS + `SADC_MCLK_NS - 1) / `SADC_MCLK_NS))
`define SADC_CONV_WAIT_CYC (6'((`SADC_CONV_MAX_NS + `SADC_MCLK_NS - 1) / `SADC_MCLK_NS))
`define SADC_CYCLE_CYC (6'((`SADC_CYCLE_MIN_NS + `SADC_MCLK_NS - 1) / `SADC_MCLK_NS))
`define SADC_SEL_WAIT 2'h3
`define SADC_PH_RISE 2'h0
`define SADC_PH_FALL 2'h2

`endif

// file: rtl/sadc_dev.sv
// Converter end: conversion timing, mode latch and serial result readout
//
// Function
// [RL1] Convert_start rise starts conversion, latches mode
// [RL2] Din high at rise selects chip-select mode
// [RL3] Din low at rise selects daisy-chain mode
// [RL4] 3-wire: convert_start low selects readout
// [RL5] 3-wire: drive output at select, MSB first
// [RL6] 3-wire: release on deselect or last fall
// [RL7] 4-wire: din low selects readout, MSB first
// [RL8] 4-wire: release on din high or last fall
// [RL9] Next bit driven after each SCLK fall
// [RL10] 3-wire: convert_start high pulse at least 10 ns
// [RL11] 4-wire: din high pulse at least 10 ns
// [RL12] 4-wire: convert_start low pulse at least 20 ns
// [RL13] Daisy: capture din on SCLK falling edges
// [RL14] Every mode with or without busy bit
// [RL15] Conversion timed by internal clock, not SCLK
// [RL16] Power down after conversion through acquisition
// [RL17] Conversion 500-710 ns; host spacing and waits
// [RL18] Host SCLK at most 66.6 MHz, 45-55% duty
`timescale 1ns/10ps
`include "sadc_defs.svh"
module sadc_dev
	import sadc_pkg::*;
(
	// Internal conversion clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Analog stand-in and variant select
	input wire logic [`SADC_RES_W-1:0] sample_i,
	input wire logic busy_ind_i,
	// Status
	output logic converting_o,
	output logic powered_down_o,
	output logic [1:0] mode_o,
	// Link
	sadc_if.dev link
);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
logic cs_meta_q, cs_sync_q, din_meta_q, din_sync_q, cs_prev_q;
logic cs_meta_d, cs_sync_d, din_meta_d, din_sync_d, cs_prev_d;

always_comb begin
	cs_meta_d = link.convert_start;
	cs_sync_d = cs_meta_q;
	din_meta_d = link.din;
	din_sync_d = din_meta_q;
	cs_prev_d = cs_sync_q;
end

always_ff @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		cs_meta_q <= 1'b0;
		cs_sync_q <= 1'b0;
		din_meta_q <= 1'b1;
		din_sync_q <= 1'b1;
		cs_prev_q <= 1'b0;
	end else begin
		cs_meta_q <= cs_meta_d;
		cs_sync_q <= cs_sync_d;
		din_meta_q <= din_meta_d;
		din_sync_q <= din_sync_d;
		cs_prev_q <= cs_prev_d;
	end
end

// ----------------------------------------
// Conversion engine on the internal clock
// ----------------------------------------
// SCLK never touches this section, so conversions keep their timing
// whatever the host does on the serial clock.
logic start_evt;
logic busy_q, busy_d;
logic [`SADC_TMR_W-1:0] conv_cnt_q, conv_cnt_d;
logic [`SADC_RES_W-1:0] samp_q, samp_d, result_q, result_d;
logic chip_sel_q, chip_sel_d, wire4_q, wire4_d, busy_ind_q, busy_ind_d;
logic pd_q, pd_d;
logic [1:0] mode_q, mode_d;

assign start_evt = cs_sync_q & ~cs_prev_q;

always_comb begin
	busy_d = busy_q;
	conv_cnt_d = conv_cnt_q;
	samp_d = samp_q;
	result_d = result_q;
	chip_sel_d = chip_sel_q;
	wire4_d = wire4_q;
	busy_ind_d = busy_ind_q;
	pd_d = pd_q;
	mode_d = mode_q;
	if (start_evt && !busy_q) begin
		busy_d = 1'b1; // see [RL1] [RL15]
		conv_cnt_d = `SADC_CONV_CYC; // see [RL17]
		samp_d = sample_i;
		chip_sel_d = din_sync_q; // see [RL1] [RL2] [RL3]
		wire4_d = 1'b0;
		busy_ind_d = busy_ind_i; // see [RL14]
		pd_d = 1'b0;
		mode_d = din_sync_q ? SADC_MODE_3W : SADC_MODE_DAISY;
	end else if (busy_q) begin
		conv_cnt_d = conv_cnt_q - 6'h01;
		if (conv_cnt_q == 6'h01) begin
			busy_d = 1'b0;
			result_d = samp_q;
			pd_d = 1'b1; // see [RL16]
		end
	end else if (chip_sel_q && cs_sync_q && !din_sync_q) begin
		// Din dropping while convert_start stays high marks the 4-wire host
		wire4_d = 1'b1; // see [RL7]
		mode_d = SADC_MODE_4W;
	end
end

always_ff @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		busy_q <= 1'b0;
		conv_cnt_q <= 6'h00;
		samp_q <= 16'h0000;
		result_q <= 16'h0000;
		chip_sel_q <= 1'b1;
		wire4_q <= 1'b0;
		busy_ind_q <= 1'b0;
		pd_q <= 1'b1;
		mode_q <= 2'h0;
	end else begin
		busy_q <= busy_d;
		conv_cnt_q <= conv_cnt_d;
		samp_q <= samp_d;
		result_q <= result_d;
		chip_sel_q <= chip_sel_d;
		wire4_q <= wire4_d;
		busy_ind_q <= busy_ind_d;
		pd_q <= pd_d;
		mode_q <= mode_d;
	end
end

assign converting_o = busy_q;
assign powered_down_o = pd_q;
assign mode_o = mode_q;

// ----------------------------------------
// Readout selection from the pins
// ----------------------------------------
// Selection is decoded straight from the pins so the first bit (MSB, or the busy marker) appears with no
// SCLK edge. Mode flags are quasi-static: they change at a conversion start,
// and wire4_q at the 4-wire select, before the first SCLK edge.
logic frame_sel;
logic link_rst;

always_comb begin
	if (!chip_sel_q)
		frame_sel = ~link.convert_start; // see [RL3]
	else if (link.convert_start)
		frame_sel = ~link.din; // see [RL7] [RL8]
	else
		frame_sel = link.din & ~wire4_q; // see [RL4] [RL6]
end

// Deselect ends the frame even though SCLK has stopped
assign link_rst = rst_i | ~frame_sel;

// ----------------------------------------
// Link-clock logic
// ----------------------------------------
logic [`SADC_CNT_W-1:0] bit_cnt_q, bit_cnt_d, frame_len;
logic [`SADC_RES_W-1:0] chain_q, chain_d;
logic [`SADC_FRAME_W-1:0] frame_word;
logic own_bits;

assign frame_len = busy_ind_q ? `SADC_LEN_BUSY : `SADC_LEN_PLAIN; // see [RL14]
// Busy variant leads with a marker bit, then the same MSB-first word
assign frame_word = busy_ind_q ? {1'b1, result_q} : {result_q, 1'b0};
assign own_bits = bit_cnt_q < frame_len;

always_comb begin
	bit_cnt_d = bit_cnt_q;
	if (own_bits)
		bit_cnt_d = bit_cnt_q + 5'h01; // see [RL9]
	chain_d = {chain_q[`SADC_RES_W-2:0], link.din}; // see [RL13]
end

always_ff @(negedge link.sclk or posedge link_rst) begin
	if (link_rst) begin
		bit_cnt_q <= 5'h00;
		chain_q <= 16'h0000;
	end else begin
		bit_cnt_q <= bit_cnt_d;
		chain_q <= chain_d;
	end
end

// ----------------------------------------
// Output pin
// ----------------------------------------
// Daisy mode passes the upstream word on once its own bits are out
always_comb begin
	if (own_bits)
		link.dout = frame_word[`SADC_MSB_IDX - bit_cnt_q]; // see [RL5] [RL7] [RL9]
	else
		link.dout = chain_q[`SADC_RES_W-1]; // see [RL13]
	link.dout_oe_n = ~(frame_sel & (own_bits | ~chip_sel_q)); // see [RL6] [RL8]
end

endmodule

// file: rtl/sadc_host.sv
// Host end: starts conversions, makes SCLK and reads results into a buffer
`timescale 1ns/10ps
`include "sadc_defs.svh"
module sadc_host
	import sadc_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Control
	input wire logic enable_i,
	input wire logic [1:0] mode_i,
	input wire logic busy_ind_i,
	// Result stream
	output logic [`SADC_RES_W-1:0] word_o,
	output logic word_valid_o,
	input wire logic word_ready_i,
	// Link
	sadc_if.host link
);

// ----------------------------------------
// Output sampling
// ----------------------------------------
logic do_meta_q, do_meta_d, do_sync_q, do_sync_d;

always_comb begin
	do_meta_d = link.dout_line;
	do_sync_d = do_meta_q;
end

always_ff @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		do_meta_q <= 1'b0;
		do_sync_q <= 1'b0;
	end else begin
		do_meta_q <= do_meta_d;
		do_sync_q <= do_sync_d;
	end
end

// ----------------------------------------
// Sequencer
// ----------------------------------------
// SCLK is mclk/4 with 50% duty, far below the converter's limit
sadc_hstate_e st_q, st_d;
logic cs_q, cs_d, din_q, din_d, sclk_q, sclk_d;
logic [`SADC_TMR_W-1:0] tmr_q, tmr_d, per_q, per_d;
logic [1:0] ph_q, ph_d, md_q, md_d;
logic [`SADC_CNT_W-1:0] bc_q, bc_d, len;
logic [`SADC_FRAME_W-1:0] rx_q, rx_d;
logic bi_q, bi_d, push, in_ready;

assign len = bi_q ? `SADC_LEN_BUSY : `SADC_LEN_PLAIN; // see [RL14]

always_comb begin
	st_d = st_q;
	cs_d = cs_q;
	din_d = din_q;
	sclk_d = sclk_q;
	tmr_d = tmr_q;
	per_d = (per_q < `SADC_CYCLE_CYC) ? per_q + 6'h01 : per_q;
	ph_d = ph_q;
	md_d = md_q;
	bc_d = bc_q;
	rx_d = rx_q;
	bi_d = bi_q;
	push = 1'b0;
	unique case (st_q)
		SADC_H_IDLE: begin
			// Back-pressure: no conversion without room for its word
			if (enable_i && in_ready && per_q >= `SADC_CYCLE_CYC) begin // see [RL17]
				md_d = mode_i;
				bi_d = busy_ind_i;
				din_d = (mode_i != SADC_MODE_DAISY); // see [RL2] [RL3]
				st_d = SADC_H_PREP;
			end
		end
		SADC_H_PREP: begin
			cs_d = 1'b1; // see [RL1]
			per_d = 6'h00;
			tmr_d = `SADC_CONV_WAIT_CYC;
			st_d = SADC_H_START;
		end
		SADC_H_START: begin
			st_d = SADC_H_CONV; // see [RL10]
		end
		SADC_H_CONV: begin
			tmr_d = tmr_q - 6'h01;
			if (tmr_q == 6'h00) begin // see [RL17]
				if (md_q == SADC_MODE_4W)
					din_d = 1'b0; // see [RL7]
				else
					cs_d = 1'b0; // see [RL4]
				ph_d = 2'h0;
				st_d = SADC_H_SEL;
			end
		end
		SADC_H_SEL: begin
			ph_d = ph_q + 2'h1;
			if (ph_q == `SADC_SEL_WAIT) begin
				bc_d = 5'h00;
				ph_d = 2'h0;
				st_d = SADC_H_SHIFT;
			end
		end
		SADC_H_SHIFT: begin
			ph_d = ph_q + 2'h1;
			if (ph_q == `SADC_PH_RISE)
				sclk_d = 1'b1; // see [RL18]
			if (ph_q == `SADC_PH_FALL) begin
				sclk_d = 1'b0;
				rx_d = {rx_q[`SADC_FRAME_W-2:0], do_sync_q}; // see [RL9]
				bc_d = bc_q + 5'h01;
			end
			if (ph_q == 2'h3 && bc_q == len)
				st_d = SADC_H_DONE;
		end
		SADC_H_DONE: begin
			push = 1'b1;
			if (md_q == SADC_MODE_4W) begin
				din_d = 1'b1; // see [RL11]
				cs_d = 1'b0; // see [RL12]
			end
			st_d = SADC_H_IDLE;
		end
		default: begin
			st_d = SADC_H_IDLE;
		end
	endcase
end

always_ff @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		st_q <= SADC_H_IDLE;
		cs_q <= 1'b0;
		din_q <= 1'b1;
		sclk_q <= 1'b0;
		tmr_q <= 6'h00;
		per_q <= 6'h00;
		ph_q <= 2'h0;
		md_q <= 2'h0;
		bc_q <= 5'h00;
		rx_q <= 17'h00000;
		bi_q <= 1'b0;
	end else begin
		st_q <= st_d;
		cs_q <= cs_d;
		din_q <= din_d;
		sclk_q <= sclk_d;
		tmr_q <= tmr_d;
		per_q <= per_d;
		ph_q <= ph_d;
		md_q <= md_d;
		bc_q <= bc_d;
		rx_q <= rx_d;
		bi_q <= bi_d;
	end
end

assign link.convert_start = cs_q;
assign link.din = din_q;
assign link.sclk = sclk_q;

// ----------------------------------------
// Two-entry result buffer
// ----------------------------------------
logic [`SADC_RES_W-1:0] head_q, head_d, tail_q, tail_d;
logic hv_q, hv_d, tv_q, tv_d, pop;

assign in_ready = ~tv_q;
assign pop = hv_q & word_ready_i;

always_comb begin
	head_d = head_q;
	tail_d = tail_q;
	hv_d = hv_q;
	tv_d = tv_q;
	if (pop) begin
		hv_d = tv_q;
		head_d = tail_q;
		tv_d = 1'b0;
	end
	if (push) begin
		if (!hv_d) begin
			hv_d = 1'b1;
			head_d = rx_q[`SADC_RES_W-1:0];
		end else begin
			tv_d = 1'b1;
			tail_d = rx_q[`SADC_RES_W-1:0];
		end
	end
end

always_ff @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		head_q <= 16'h0000;
		tail_q <= 16'h0000;
		hv_q <= 1'b0;
		tv_q <= 1'b0;
	end else begin
		head_q <= head_d;
		tail_q <= tail_d;
		hv_q <= hv_d;
		tv_q <= tv_d;
	end
end

assign word_o = head_q;
assign word_valid_o = hv_q;

endmodule

// file: rtl/sadc_if.sv
// Pin-level link between the converter and its host
`timescale 1ns/10ps
interface sadc_if;
	logic convert_start;
	logic din;
	logic sclk;
	logic dout;
	logic dout_oe_n;
	wire dout_line;

	// Released pin reads low, as a pull-down would hold it
	assign dout_line = dout & ~dout_oe_n;

	modport dev (
		input convert_start,
		input din,
		input sclk,
		output dout,
		output dout_oe_n
	);

	modport host (
		output convert_start,
		output din,
		output sclk,
		input dout_line
	);
endinterface

// file: rtl/sadc_pkg.sv
// Types shared by both ends of the converter readout link
package sadc_pkg;

	typedef enum logic [1:0] {
		SADC_MODE_3W = 2'b00,
		SADC_MODE_4W = 2'b01,
		SADC_MODE_DAISY = 2'b10
	} sadc_mode_e;

	typedef enum logic [2:0] {
		SADC_H_IDLE = 3'b000,
		SADC_H_PREP = 3'b001,
		SADC_H_START = 3'b010,
		SADC_H_CONV = 3'b011,
		SADC_H_SEL = 3'b100,
		SADC_H_SHIFT = 3'b101,
		SADC_H_DONE = 3'b110
	} sadc_hstate_e;

endpackage

// file: verification/sadc_link_checker.sv
// Checker for the converter link: pin timing and conversion rules at the mclk rate
`timescale 1ns/10ps
module sadc_link_checker (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Link pins
	input wire logic convert_start,
	input wire logic din,
	input wire logic sclk,
	input wire logic dout,
	input wire logic dout_oe_n,
	// Converter status
	input wire logic busy_ind_i,
	input wire logic converting_o,
	input wire logic powered_down_o,
	input wire logic [1:0] mode_o
);
	logic cs_q;
	logic sclk_q;
	logic mode_cs_q;
	logic [4:0] fall_cnt_q;
	logic [4:0] conv_cnt_q;

	// ----
	// Helpers
	// ----
	// Mode latched one edge late, so rules gated by it skip the start edge itself
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_q <= 1'b0;
			sclk_q <= 1'b0;
			mode_cs_q <= 1'b0;
			fall_cnt_q <= 5'h00;
			conv_cnt_q <= 5'h00;
		end else begin
			cs_q <= convert_start;
			sclk_q <= sclk;
			if (convert_start && !cs_q) begin
				mode_cs_q <= din;
			end
			fall_cnt_q <= dout_oe_n ? 5'h00 : fall_cnt_q + 5'(sclk_q & ~sclk);
			conv_cnt_q <= converting_o ? conv_cnt_q + 5'h01 : 5'h00;
		end
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	// ----
	// Assertions
	// ----
	a_start_conv: assert property (
		$rose(convert_start) && !converting_o |-> ##[3:4] converting_o)
		else $error("conversion did not start after convert_start rise");
	a_mode_daisy: assert property (
		$rose(convert_start) && !din && !converting_o |-> ##[3:4] mode_o == 2'h2)
		else $error("daisy mode not taken with din low");
	a_mode_cs: assert property (
		$rose(convert_start) && din && !converting_o |-> ##[3:4] mode_o == 2'h0)
		else $error("chip-select mode not taken with din high");
	a_conv_len: assert property (
		$fell(converting_o) |-> conv_cnt_q == 5'h0D ##[0:1] powered_down_o)
		else $error("conversion length or power down wrong");
	a_awake_conv: assert property (
		converting_o && $past(converting_o) |-> !powered_down_o)
		else $error("powered down during conversion");
	a_sel_three: assert property (
		mode_cs_q && $fell(convert_start) && din && $stable(din) |-> !dout_oe_n)
		else $error("output not driven at 3-wire select");
	a_sel_four: assert property (
		mode_cs_q && convert_start && $fell(din) |-> !dout_oe_n)
		else $error("output not driven at 4-wire select");
	a_rel_desel: assert property (
		mode_cs_q && convert_start && din |-> dout_oe_n)
		else $error("output driven while deselected");
	a_rel_count: assert property (
		mode_cs_q && $fell(sclk) && fall_cnt_q == (busy_ind_i ? 5'h10 : 5'h0F) |-> dout_oe_n)
		else $error("output not released after last fall");
	a_bit_hold: assert property (
		!dout_oe_n && !$past(dout_oe_n) && $changed(dout) |-> $fell(sclk))
		else $error("output bit changed away from sclk fall");
	// Chain output must stay on the pin for the downstream reader
	a_daisy_drive: assert property (
		mode_o == 2'h2 && !convert_start |-> !dout_oe_n)
		else $error("output released while daisy chain selected");

	c_conv_done: cover property ($fell(converting_o));
	c_three_frame: cover property (mode_cs_q && $fell(convert_start) && din);
	c_daisy_frame: cover property (mode_o == 2'h2 && !dout_oe_n);
	c_four_frame: cover property (mode_cs_q && convert_start && $fell(din));
endmodule

// file: verification/sar_adc_serial_readout_tb.sv
// Testbench: host and converter joined over the link, results checked end to end
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
	total_checks++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("ERROR %s expected %0h seen %0h", nm, exp, got); \
	end \
end
module sar_adc_serial_readout_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic enable = 1'b0;
	logic [1:0] mode = 2'h0;
	logic busy = 1'b0;
	logic [15:0] sample = 16'h0000;
	logic ready = 1'b0;
	logic [15:0] word;
	logic valid;
	logic conv;
	logic pdn;
	logic [1:0] dmode;
	int n_mismatch = 0;
	int total_checks = 0;

	always #20 mclk = ~mclk;

	// ----
	// Both ends over one link
	// ----
	sadc_if link_if();
	sadc_dev sadc_dev_i (.mclk_i(mclk), .rst_i(rst), .sample_i(sample), .busy_ind_i(busy),
		.converting_o(conv), .powered_down_o(pdn), .mode_o(dmode), .link(link_if.dev));
	sadc_host sadc_host_i (.mclk_i(mclk), .rst_i(rst), .enable_i(enable), .mode_i(mode),
		.busy_ind_i(busy), .word_o(word), .word_valid_o(valid), .word_ready_i(ready),
		.link(link_if.host));
	sadc_link_checker sadc_link_checker_i (.mclk_i(mclk), .rst_i(rst),
		.convert_start(link_if.convert_start), .din(link_if.din), .sclk(link_if.sclk),
		.dout(link_if.dout), .dout_oe_n(link_if.dout_oe_n), .busy_ind_i(busy),
		.converting_o(conv), .powered_down_o(pdn), .mode_o(dmode));

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Long enough for any frame in flight to finish and leave the buffer
	task automatic flush;
		enable <= 1'b0;
		ready <= 1'b1;
		repeat (120) @(posedge mclk);
	endtask

	// ----
	// Scenarios
	// ----
	// Every mode in both variants, boundary sample values
	task automatic mode_sweep;
		logic [15:0] tbl [6];
		int i;
		int k;
		tbl = '{16'h8001, 16'h7FFE, 16'hFFFF, 16'h0000, 16'hA5C3, 16'h5A3C};
		for (k = 0; k < 6; k++) begin
			flush();
			mode <= 2'(k / 2);
			busy <= k[0];
			sample <= tbl[k];
			enable <= 1'b1;
			for (i = 0; i < 400 && valid !== 1'b1; i++) @(posedge mclk);
			if (valid !== 1'b1) begin
				n_mismatch++;
				$display("ERROR word_valid expected 1 seen %b", valid);
				stop_test();
			end
			`CHK("word_o", tbl[k], word)
			`CHK("mode_o", 2'(k / 2), dmode)
			enable <= 1'b0;
		end
		$display("test mode_sweep done");
	endtask

	// Receiver stalls: buffer fills, host stops starting, nothing is lost
	task automatic stall_fill;
		int i;
		int n;
		n = 0;
		flush();
		mode <= 2'h1;
		busy <= 1'b0;
		sample <= 16'h1234;
		ready <= 1'b0;
		enable <= 1'b1;
		repeat (300) @(posedge mclk);
		`CHK("word_valid_o", 1'b1, valid)
		`CHK("powered_down_o", 1'b1, pdn)
		enable <= 1'b0;
		ready <= 1'b1;
		for (i = 0; i < 150; i++) begin
			@(posedge mclk);
			if (valid === 1'b1) begin
				n++;
				`CHK("word_o", 16'h1234, word)
			end
		end
		`CHK("pops", 2, n)
		$display("test stall_fill done");
	endtask

	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		mode_sweep();
		stall_fill();
		stop_test();
	end
endmodule
